// ===== hw/dcrc_top.sv
// dual serial 32-bit crc: transmit encoder and receive checker
`include "dcrc_regs.svh"

// Contract
// - receiver runs same generator, flags corrupted frames
// - output mux: payload when control/pass, else top
// - transmit term: top xor data, gated
// - stage 0 loads term; preset loads ones
// - tapped transmit stages xor term in
// - untapped transmit stages shift plainly
// - receive term: top xor input, zero on preset
// - receive register uses same taps
// - enable low registers encoded input through
// - ready flag registered from counter all ones
// - every shift stage is a clocked register
// - good frame leaves fixed residue, else error
// - counter counts control low, cleared control high
module dcrc_top
  import dcrc_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // transmit pins
  input  wire logic serial_payload_in,
  input  wire logic feedback_ctl_line,
  input  wire logic tx_preset,
  input  wire logic pass_through_en,
  output logic      encoded_serial_out,
  output logic      check_out_done_flag,
  // receive pins
  input  wire logic rx_encoded_in,
  input  wire logic rx_preset,
  input  wire logic rx_output_enable_n,
  output logic      frame_error_flag,
  // receive pass-through stream
  output logic      rx_serial_out,
  output logic      rx_serial_valid,
  input  wire logic rx_sink_ready,
  output logic      rx_in_ready
);

  // pin synchronisers: first stage feeds only the second
  localparam int PINS = 7;
  localparam logic [PINS-1:0] PIN_IDLE = {1'b1, {(PINS-1){1'b0}}};  // idle levels: receive enable off
  logic [PINS-1:0] pinRaw;         // pins as sampled
  logic [PINS-1:0] syncMeta;       // first stage
  logic [PINS-1:0] syncPin;        // second stage, safe to read

  // synchronised pin levels
  logic            sPay;           // serial payload bit
  logic            sCtl;           // feedback control
  logic            sTxPre;         // transmit preset
  logic            sPass;          // pass-through enable
  logic            sRxIn;          // received encoded bit
  logic            sRxPre;         // receive preset
  logic            sOeN;           // receive output enable, low active

  // transmit section
  dcrc_word_t      txState;        // transmit shift register
  logic            tx_feedback_term;
  logic            next_encOut;
  dcrc_cnt_t       cnt;            // check bit counter
  dcrc_cnt_t       next_cnt;
  logic            counter_top_bit;
  logic            counter_low_bits_all_ones;
  logic            next_doneFlag;

  // receive section
  dcrc_word_t      rxState;        // receive shift register
  logic            rx_feedback_term;
  logic            rx_lfsr_stage0;
  logic            next_errFlag;

  // gather the pins for the synchroniser
  assign pinRaw = {rx_output_enable_n, rx_preset, rx_encoded_in,
                   pass_through_en, tx_preset, feedback_ctl_line, serial_payload_in};

  // two flip-flops on every gathered pin; rx_sink_ready goes to the buffer unsynchronised
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncMeta <= PIN_IDLE;
      syncPin  <= PIN_IDLE;
    end
    else
    begin
      syncMeta <= pinRaw;
      syncPin  <= syncMeta;
    end
  end

  // name the synchronised levels
  assign sPay   = syncPin[0];
  assign sCtl   = syncPin[1];
  assign sTxPre = syncPin[2];
  assign sPass  = syncPin[3];
  assign sRxIn  = syncPin[4];
  assign sRxPre = syncPin[5];
  assign sOeN   = syncPin[6];

  // transmit feedback only while control high and preset low
  assign tx_feedback_term = sCtl & ~sTxPre & (txState[`DCRC_WIDTH-1] ^ sPay);

  // transmit register: taps and plain stages set by the mask
  dcrc_lfsr #(
    .WIDTH (`DCRC_WIDTH),
    .TAPS  (`DCRC_TAPS)
  ) u_tx_lfsr (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .preset  (sTxPre),
    .term    (tx_feedback_term),
    .state   (txState)
  );

  // receive feedback has no control gating, only preset forces zero
  assign rx_feedback_term = ~sRxPre & (rxState[`DCRC_WIDTH-1] ^ sRxIn);

  // receive register shares the generator taps
  dcrc_lfsr #(
    .WIDTH (`DCRC_WIDTH),
    .TAPS  (`DCRC_TAPS)
  ) u_rx_lfsr (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .preset  (sRxPre),
    .term    (rx_feedback_term),
    .state   (rxState)
  );

  // stage zero of the receiver, kept for observation
  assign rx_lfsr_stage0 = rxState[0];

  // output mux and counter next values
  always_comb
  begin
    // payload passes when control or pass-through is high
    if (sCtl || sPass)
      next_encOut = sPay;
    else
      next_encOut = txState[`DCRC_WIDTH-1];
    // counter cleared while control high, counts while low
    if (sCtl)
      next_cnt = `DCRC_CNT_ZERO;
    else if (cnt != `DCRC_CNT_FULL)
      next_cnt = cnt + `DCRC_CNT_ONE;
    else
      next_cnt = cnt;                         // hold at all ones
  end

  // counter decode for the ready flag
  assign counter_top_bit           = cnt[`DCRC_CNT_TOP];
  assign counter_low_bits_all_ones = &cnt[`DCRC_CNT_TOP-1:0];

  // ready flag is top bit and the low bits all set
  always_comb
  begin
    next_doneFlag = counter_top_bit & counter_low_bits_all_ones;
  end

  // register transmit outputs and counter
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      encoded_serial_out  <= 1'b0;
      cnt                 <= `DCRC_CNT_ZERO;
      check_out_done_flag <= 1'b0;
    end
    else
    begin
      encoded_serial_out  <= next_encOut;
      cnt                 <= next_cnt;
      check_out_done_flag <= next_doneFlag;
    end
  end

  // error when any stage, stage 22 included, differs from the residue
  always_comb
  begin
    next_errFlag = (rxState != `DCRC_RESIDUE);
  end

  // register the error flag
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      frame_error_flag <= 1'b0;
    else
      frame_error_flag <= next_errFlag;
  end

  // pass-through copy: a stall by the sink holds two bits, later bits are dropped
  logic bufInValid;  // push request while output enabled
  assign bufInValid = ~sOeN;

  dcrc_skid #(
    .WIDTH (1),
    .DEPTH (`DCRC_BUF_DEPTH)
  ) u_rx_buf (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .inValid  (bufInValid),
    .inData   (sRxIn),
    .inReady  (rx_in_ready),
    .outValid (rx_serial_valid),
    .outData  (rx_serial_out),
    .outReady (rx_sink_ready)
  );

  // checks guarding the transmit and receive logic
  default clocking dcrc_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // a preset pulse followed by one idle shift
  sequence txPresetPulse;
    sTxPre ##1 (!sTxPre && !sCtl);
  endsequence

  // control high on two cycles in a row
  sequence ctlHeld;
    sCtl [*2];
  endsequence

  // payload passes the mux when control or pass is high
  chk_enc_mux_data: assert property ((sCtl || sPass) |=> encoded_serial_out == $past(sPay))
    else $error("encoded output is not the payload bit");

  // top stage passes the mux when both are low
  chk_enc_mux_check: assert property (!sCtl && !sPass |=> encoded_serial_out == $past(txState[31]))
    else $error("encoded output is not the top transmit stage");

  // transmit term is zero unless control high and preset low
  chk_tx_term_gate: assert property ((!sCtl || sTxPre) |-> !tx_feedback_term)
    else $error("transmit term not gated off");

  // preset then a plain shift gives ones with a zero at stage 0
  chk_tx_preset_shift: assert property (txPresetPulse |=> txState == `DCRC_ONES_SHIFTED)
    else $error("transmit register wrong after preset and shift");

  // with feedback on, tapped stages take the term
  chk_tx_tap_step: assert property (sCtl && !sTxPre |=>
    txState == ({$past(txState[30:0]), 1'b0} ^ ($past(tx_feedback_term) ? `DCRC_TAPS : '0)))
    else $error("transmit tapped step wrong");

  // with control low and preset low every stage shifts plainly
  chk_tx_plain_shift: assert property (!sCtl && !sTxPre |=> txState == {$past(txState[30:0]), 1'b0})
    else $error("transmit plain shift wrong");

  // receive term is forced to zero during preset
  chk_rx_term_preset: assert property (sRxPre |-> !rx_feedback_term)
    else $error("receive term not zero during preset");

  // receive register steps with the same taps
  chk_rx_tap_step: assert property (!sRxPre |=>
    rxState == ({$past(rxState[30:0]), 1'b0} ^ ($past(rx_feedback_term) ? `DCRC_TAPS : '0)))
    else $error("receive step wrong");

  // stage zero follows the receive term
  chk_rx_stage0: assert property (!sRxPre |=> rx_lfsr_stage0 == $past(rx_feedback_term))
    else $error("receive stage zero wrong");

  // error flag tracks the residue one cycle later
  chk_err_residue: assert property (1'b1 |=> frame_error_flag == ($past(rxState) != `DCRC_RESIDUE))
    else $error("error flag disagrees with residue");

  // enabled input with room is taken into the buffer
  chk_rx_pass_take: assert property (!sOeN && rx_in_ready && !rx_serial_valid |=> rx_serial_valid)
    else $error("pass-through bit not buffered");

  // control held high keeps the counter cleared
  chk_cnt_clear: assert property (ctlHeld |-> cnt == `DCRC_CNT_ZERO)
    else $error("counter not cleared under control high");

  // counter steps by one while control low below full
  chk_cnt_step: assert property (!sCtl && cnt != `DCRC_CNT_FULL |=> cnt == $past(cnt) + `DCRC_CNT_ONE)
    else $error("counter did not step");

  // ready flag follows the counter at all ones
  chk_ready_flag: assert property (1'b1 |=> check_out_done_flag == ($past(cnt) == `DCRC_CNT_FULL))
    else $error("ready flag disagrees with counter");

  // a cleared counter drops the ready flag
  chk_done_clear: assert property (ctlHeld |=> !check_out_done_flag)
    else $error("ready flag still high under control high");

  // counter saturates at all ones while control stays low
  chk_cnt_hold: assert property (!sCtl && cnt == `DCRC_CNT_FULL |=> cnt == `DCRC_CNT_FULL)
    else $error("counter left all ones");

  // transmit stage zero takes the feedback term
  chk_tx_stage0: assert property (!sTxPre |=> txState[0] == $past(tx_feedback_term))
    else $error("transmit stage zero wrong");

  // receive preset loads all ones
  chk_rx_preset_ones: assert property (sRxPre |=> rxState == `DCRC_ONES)
    else $error("receive register not all ones after preset");

  // the fixed residue clears the error flag
  chk_err_good_frame: assert property (rxState == `DCRC_RESIDUE |=> !frame_error_flag)
    else $error("error flag set on a good residue");
endmodule

// ===== hw/dcrc_regs.svh
// constants of the dual serial crc block
`ifndef DCRC_REGS_SVH
`define DCRC_REGS_SVH

// width of each check register
`define DCRC_WIDTH        32
// generator taps: stages 0,1,2,4,5,7,8,10,11,12,16,22,23,26
`define DCRC_TAPS         32'h04C1_1DB7
// preset value of every stage
`define DCRC_ONES         32'hFFFF_FFFF
// residue of a good frame with complemented check bits, bit 31 first
`define DCRC_RESIDUE      32'hC704_DD7B
// the value one step after a preset with zero feedback
`define DCRC_ONES_SHIFTED 32'hFFFF_FFFE
// width of the check bit counter
`define DCRC_CNT_W        5
// counter value at which the last check bit is out
`define DCRC_CNT_FULL     5'h1F
// counter value while cleared
`define DCRC_CNT_ZERO     5'h00
// counter step
`define DCRC_CNT_ONE      5'h01
// index of the counter top bit
`define DCRC_CNT_TOP      4
// depth of the pass-through buffer
`define DCRC_BUF_DEPTH    2

`endif

// ===== hw/dcrc_pkg.sv
// types shared by the dual serial crc block
package dcrc_pkg;
  `include "dcrc_regs.svh"

  // one check register
  typedef logic [`DCRC_WIDTH-1:0] dcrc_word_t;
  // check bit counter
  typedef logic [`DCRC_CNT_W-1:0] dcrc_cnt_t;
endpackage

// ===== hw/dcrc_lfsr.sv
// one serial crc shift register with preset
`include "dcrc_regs.svh"

module dcrc_lfsr
  import dcrc_pkg::*;
#(
  parameter int                    WIDTH = `DCRC_WIDTH,
  parameter logic [`DCRC_WIDTH-1:0] TAPS  = `DCRC_TAPS
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // control and feedback
  input  wire logic             preset,
  input  wire logic             term,
  // register contents
  output logic [WIDTH-1:0]      state
);

  logic [WIDTH-1:0] next_state;  // value loaded at the next edge

  // the tap mask is sized for the standard width only
  if (WIDTH != `DCRC_WIDTH)
  begin : g_bad_width
    $error("dcrc_lfsr: WIDTH must equal the check register width");
  end

  // shift, xor the term into tapped stages, or load all ones
  always_comb
  begin
    if (preset)
      next_state = WIDTH'(`DCRC_ONES);
    else
      next_state = {state[WIDTH-2:0], 1'b0} ^ (TAPS & {WIDTH{term}});
  end

  // stages are plain clocked registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state <= WIDTH'(`DCRC_ONES);
    else
      state <= next_state;
  end

  // a preset leaves every stage at one
  chk_lfsr_preset_ones: assert property (@(posedge clk_sys) disable iff (!rst_b)
    preset |=> state == WIDTH'(`DCRC_ONES))
    else $error("shift register not all ones after preset");
endmodule

// ===== hw/dcrc_skid.sv
// small buffer with valid and ready on both sides
`include "dcrc_regs.svh"

module dcrc_skid
  import dcrc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = `DCRC_BUF_DEPTH
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // draining side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);

  logic [WIDTH-1:0] mem      [DEPTH];  // entry 0 is the head
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [DEPTH-1:0] vld;               // entry holds a word
  logic [DEPTH-1:0] next_vld;
  logic             placed;            // push already stored

  // at least two entries are needed to ride out a stall
  if (DEPTH < 2 || WIDTH < 1)
  begin : g_bad_depth
    $error("dcrc_skid: DEPTH must be at least 2 and WIDTH at least 1");
  end

  // pop shifts toward the head, push fills the first free slot
  always_comb
  begin
    placed   = 1'b0;
    next_mem = mem;
    next_vld = vld;
    if (outReady && vld[0])
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        next_mem[i] = mem[i+1];
        next_vld[i] = vld[i+1];
      end
      next_vld[DEPTH-1] = 1'b0;
    end
    if (inValid && !vld[DEPTH-1])
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (!placed && !next_vld[i])
        begin
          next_mem[i] = inData;
          next_vld[i] = 1'b1;
          placed      = 1'b1;
        end
      end
    end
  end

  // register the entries
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      inReady <= 1'b1;
      vld <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end
    else
    begin
      inReady <= !next_vld[DEPTH-1];  // registered so the top port comes from a flop
      vld <= next_vld;
      mem <= next_mem;
    end
  end

  // valid and data come straight from the head entry
  assign outValid = vld[0];
  assign outData  = mem[0];

  // a stalled head is held unchanged
  chk_skid_hold_head: assert property (@(posedge clk_sys) disable iff (!rst_b)
    outValid && !outReady |=> outValid && outData == $past(outData))
    else $error("buffer head changed while stalled");
endmodule

// ===== tb/dcrc_framer.sv
// far-side framing logic model that drives the crc pins
module dcrc_framer
(
  // clock
  input  wire logic clk_sys,
  // transmit framing pins
  output logic      payload,
  output logic      ctl,
  output logic      txPreset,
  output logic      passEn,
  // receive framing pins
  output logic      rxBit,
  output logic      rxPreset,
  output logic      rxOeN,
  output logic      sinkReady
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels from time zero: no preset, receive enable off
  initial
  begin
    {payload, ctl, txPreset, passEn} = 4'h0;
    {rxBit, rxPreset, rxOeN, sinkReady} = 4'h3;
  end

  // one transmit bit time: preset pulse, control level, data
  task automatic tx_step(input logic pr, input logic c, input logic pe, input logic d);
    @(negedge clk_sys);
    txPreset = pr;
    ctl      = c;
    passEn   = pe;
    payload  = d;
  endtask

  // one receive bit time; callers toggle an idle line each cycle
  task automatic rx_step(input logic pr, input logic oeN, input logic sr, input logic d);
    @(negedge clk_sys);
    rxPreset  = pr;
    rxOeN     = oeN;
    sinkReady = sr;
    rxBit     = d;
  endtask
endmodule

// ===== tb/dcrc_top_tb.sv
// self-checking bench of the dual serial crc block
module dcrc_top_tb
  import dcrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] GEN = 32'h04C11DB7; // taps 0,1,2,4,5,7,8,10,11,12,16,22,23,26
  localparam logic [15:0] PAT = 16'hA5C3;     // payload, sent lsb first

  logic       clk_sys;                        // system clock
  logic       rst_b;                          // async reset, active low
  logic       payload, ctl, txPreset, passEn; // transmit pins
  logic       rxBit, rxPreset, rxOeN;         // receive pins
  logic       sinkReady;                      // pass-through sink ready
  logic       encOut, doneFlag, errFlag;      // design flags and output
  logic       rxOut, rxValid, rxInReady;      // pass-through stream
  int         err_count, num_checks, cycles;  // bookkeeping
  logic       qr[$], qc[$], qp[$], qd[$], qe[$]; // transmit step table
  logic       got[$];                         // popped pass-through bits
  dcrc_word_t crc;                            // reference check register

  dcrc_framer u_far (.clk_sys(clk_sys), .payload(payload), .ctl(ctl), .txPreset(txPreset),
    .passEn(passEn), .rxBit(rxBit), .rxPreset(rxPreset), .rxOeN(rxOeN), .sinkReady(sinkReady));

  dcrc_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .serial_payload_in(payload),
    .feedback_ctl_line(ctl), .tx_preset(txPreset), .pass_through_en(passEn),
    .encoded_serial_out(encOut), .check_out_done_flag(doneFlag), .rx_encoded_in(rxBit),
    .rx_preset(rxPreset), .rx_output_enable_n(rxOeN), .frame_error_flag(errFlag),
    .rx_serial_out(rxOut), .rx_serial_valid(rxValid), .rx_sink_ready(sinkReady),
    .rx_in_ready(rxInReady));

  // free-running clock, 20 ns period
  initial
  begin
    clk_sys = 1'b0;
    rst_b   = 1'b0;
  end
  always #10 clk_sys = ~clk_sys;

  // compare one value and count it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // counts, verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      complete_run();
    end
  end

  // collect every bit popped from the pass-through buffer
  always @(posedge clk_sys)
    if (rxValid === 1'b1 && sinkReady)
      got.push_back(rxOut);

  // reference generator step, serial msb-out register
  function automatic dcrc_word_t crc_step(dcrc_word_t s, logic d);
    return (s << 1) ^ ((s[31] ^ d) ? GEN : 32'h0);
  endfunction

  // append one transmit step with its expected encoded bit
  task automatic push(input logic r, input logic c, input logic p, input logic d, input logic e);
    qr.push_back(r);
    qc.push_back(c);
    qp.push_back(p);
    qd.push_back(d);
    qe.push_back(e);
  endtask

  // play the step table; encoded bit shows three falling edges later
  task automatic run_tx(input int fi);
    int n;
    n = qd.size();
    for (int i = 0; i < n + 3; i++)
    begin
      if (i < n)
        u_far.tx_step(qr[i], qc[i], qp[i], qd[i]);
      else
        u_far.tx_step(1'b0, qc[n-1], qp[n-1], qd[n-1]);
      if (i >= 3)
        check("encoded out", encOut, qe[i-3]);
      if (i == fi)
        check("done flag early", doneFlag, 1'b0);
    end
    qr.delete();
    qc.delete();
    qp.delete();
    qd.delete();
    qe.delete();
  endtask

  // preset, payload, complemented check bits, then read the error flag
  task automatic rx_frame(input int flip, input logic bad);
    dcrc_word_t s;
    logic       b;
    s = 32'hFFFFFFFF;
    u_far.rx_step(1'b1, 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 48; i++)
    begin
      b = (i < 16) ? PAT[i] : ~s[47-i];
      if (i < 16)
        s = crc_step(s, b);
      u_far.rx_step(1'b0, 1'b1, 1'b1, b ^ (i == flip));
    end
    repeat (4) u_far.rx_step(1'b0, 1'b1, 1'b1, ~rxBit);
    check("frame error", errFlag, bad);
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    // frame: preset, payload with feedback, check bits, zero flush
    crc = 32'hFFFFFFFF;
    push(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      push(1'b0, 1'b1, 1'b0, PAT[i], PAT[i]);
      crc = crc_step(crc, PAT[i]);
    end
    for (int j = 0; j < 32; j++)
      push(1'b0, 1'b0, 1'b0, ~crc[31-j], crc[31-j]);
    repeat (6) push(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    run_tx(50);
    check("done flag set", doneFlag, 1'b1);
    repeat (6) u_far.tx_step(1'b0, 1'b1, 1'b0, 1'b0);
    check("done flag clear", doneFlag, 1'b0);
    // pass-through enable forces payload whatever the control level; a preset rides along
    for (int i = 0; i < 8; i++)
      push((i == 1), i[0], 1'b1, PAT[i], PAT[i]);
    run_tx(-1);
    $display("test transmit done");
    rx_frame(-1, 1'b0);
    rx_frame(5, 1'b1);
    rx_frame(40, 1'b1);
    rx_frame(-1, 1'b0);
    $display("test receive done");
    // pass-through stream with the sink always ready
    got.delete();
    for (int i = 0; i < 8; i++)
      u_far.rx_step(1'b0, 1'b0, 1'b1, PAT[i]);
    repeat (6) u_far.rx_step(1'b0, 1'b1, 1'b1, ~rxBit);
    check("pass count", got.size(), 8);
    for (int i = 0; i < 8; i++)
      check("pass bit", got[i], PAT[i]);
    // sink stalls: two bits held, third refused, then drained
    got.delete();
    for (int i = 0; i < 3; i++)
      u_far.rx_step(1'b0, 1'b0, 1'b0, PAT[i+8]);
    repeat (4) u_far.rx_step(1'b0, 1'b1, 1'b0, ~rxBit);
    check("in ready full", rxInReady, 1'b0);
    check("head valid", rxValid, 1'b1);
    repeat (4) u_far.rx_step(1'b0, 1'b1, 1'b1, ~rxBit);
    check("drain count", got.size(), 2);
    check("drain bit0", got[0], PAT[8]);
    check("drain bit1", got[1], PAT[9]);
    check("empty valid", rxValid, 1'b0);
    check("empty ready", rxInReady, 1'b1);
    $display("test pass-through done");
    complete_run();
  end
endmodule
